// File: iss_slave_ctrl.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module iss_slave_ctrl
  import iss_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // I2C clock line
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE,
  // I2C data line
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  // System
  input  wire logic        SYSCLK_FROM_HS,
  output logic             EVENT_PULSE,
  output logic             WAKE_REQ
);

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  iss_regs_t   s_q;
  iss_regs_t   s_d;
  logic        scl_f;
  logic        sda_f;
  logic        bypass;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        acc_setup;
  logic        acc_done;
  logic        hit;
  logic [31:0] rd_word;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // Line filters
  // ----------------------------------------
  assign bypass = s_q.wake_en & ~SYSCLK_FROM_HS; // R15

  iss_pin_filter u_scl_filt (
    .clk     (REF_CLK),
    .rst_n   (rst_n),
    .pin     (SCL_IN),
    .deb_sel (s_q.deb_sel),
    .bypass  (bypass),
    .filt    (scl_f)
  );

  iss_pin_filter u_sda_filt (
    .clk     (REF_CLK),
    .rst_n   (rst_n),
    .pin     (SDA_IN),
    .deb_sel (s_q.deb_sel),
    .bypass  (bypass),
    .filt    (sda_f)
  );

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  assign scl_rise = scl_f & ~s_q.scl_d;
  assign scl_fall = ~scl_f & s_q.scl_d;
  assign start_c  = scl_f & s_q.scl_d & ~sda_f & s_q.sda_d;
  assign stop_c   = scl_f & s_q.scl_d & sda_f & ~s_q.sda_d;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign acc_setup = PSEL & PENABLE & ~s_q.pready;
  assign acc_done  = PSEL & PENABLE & s_q.pready;

  always_comb
  begin
    hit     = 1'b1;
    rd_word = 32'h0;
    case (PADDR)
      OFF_STATUS_CTRL:
        rd_word[7:0] = {s_q.byte_done, s_q.addr_match, s_q.bus_busy, s_q.tx_role,
                        s_q.ack_to_send, s_q.master_dir, s_q.wake_en, s_q.ack_rx_n};
      OFF_OWN_ADDR:
        rd_word[7:0] = {s_q.own_addr, 1'b0};
      OFF_SHIFT_DATA:
        rd_word[7:0] = s_q.shift;
      OFF_PORT_CTRL:
        rd_word[7:0] = {4'h0, s_q.deb_sel, s_q.port_en, 1'b0};
      default:
        hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d         = s_q;
    s_d.event_p = 1'b0;
    s_d.wake_p  = 1'b0;
    s_d.scl_d   = scl_f;
    s_d.sda_d   = sda_f;
    s_d.pready  = acc_setup;
    if (acc_setup)
    begin
      s_d.prdata  = rd_word;
      s_d.pslverr = ~hit;
    end

    // Register writes
    if (acc_done && PWRITE)
    begin
      case (PADDR)
        OFF_STATUS_CTRL:
        begin
          s_d.tx_role     = PWDATA[BIT_TXROLE];
          s_d.ack_to_send = PWDATA[BIT_ACKSEND];
          s_d.wake_en     = PWDATA[BIT_WAKEEN]; // R18
        end
        OFF_OWN_ADDR:
          s_d.own_addr = PWDATA[7:1];
        OFF_SHIFT_DATA:
        begin
          if (!(s_q.phase == PH_TX || s_q.phase == PH_TX_ACK))
            s_d.shift = PWDATA[7:0];
        end
        OFF_PORT_CTRL:
        begin
          s_d.deb_sel = PWDATA[POS_DEB+1:POS_DEB];
          s_d.port_en = PWDATA[BIT_PORTEN];
          if (PWDATA[BIT_PORTEN] && !s_q.port_en)
          begin
            s_d.byte_done  = SC_RESET[BIT_DONE]; // R14
            s_d.addr_match = SC_RESET[BIT_MATCH];
            s_d.bus_busy   = SC_RESET[BIT_BUSY];
            s_d.master_dir = SC_RESET[BIT_DIR];
            s_d.ack_rx_n   = SC_RESET[BIT_ACKRXN];
          end
        end
        default:
        begin
        end
      endcase
    end

    // Bus engine
    if (!s_q.port_en)
      s_d.phase = PH_IDLE;
    else if (start_c)
    begin
      s_d.bus_busy = 1'b1; // R3
      s_d.phase    = PH_ADDR;
      s_d.bit_cnt  = 4'h0;
    end
    else if (stop_c)
    begin
      s_d.bus_busy = 1'b0; // R3
      s_d.phase    = PH_IDLE;
    end
    else
    begin
      case (s_q.phase)
        PH_ADDR:
        begin
          if (scl_rise)
          begin
            s_d.shift   = {s_q.shift[6:0], sda_f};
            s_d.bit_cnt = 4'(s_q.bit_cnt + 4'h1);
            if (s_q.bit_cnt == 4'h0)
              s_d.byte_done = 1'b0; // R19
            if (s_q.bit_cnt == BYTE_BITS - 4'h1)
            begin
              s_d.master_dir = sda_f; // R8 R16
              s_d.addr_match = (s_q.shift[6:0] == s_q.own_addr); // R2
              s_d.byte_done  = 1'b1;
              if (s_q.shift[6:0] == s_q.own_addr)
              begin
                s_d.event_p = 1'b1;
                s_d.wake_p  = s_q.wake_en; // R10
              end
            end
          end
          else if (scl_fall && s_q.bit_cnt == BYTE_BITS)
            s_d.phase = s_q.addr_match ? PH_ADDR_ACK : PH_SKIP; // R17
        end
        PH_RX:
        begin
          if (scl_rise)
          begin
            s_d.shift   = {s_q.shift[6:0], sda_f};
            s_d.bit_cnt = 4'(s_q.bit_cnt + 4'h1);
            if (s_q.bit_cnt == 4'h0)
              s_d.byte_done = 1'b0; // R1 R19
            if (s_q.bit_cnt == BYTE_BITS - 4'h1)
            begin
              s_d.byte_done = 1'b1; // R1
              s_d.event_p   = 1'b1;
            end
          end
          else if (scl_fall && s_q.bit_cnt == BYTE_BITS)
            s_d.phase = PH_RX_ACK; // R5
        end
        PH_TX:
        begin
          if (scl_rise)
          begin
            s_d.bit_cnt = 4'(s_q.bit_cnt + 4'h1);
            if (s_q.bit_cnt == 4'h0)
              s_d.byte_done = 1'b0; // R1 R19
          end
          else if (scl_fall)
          begin
            s_d.shift = {s_q.shift[6:0], 1'b0};
            if (s_q.bit_cnt == BYTE_BITS)
              s_d.phase = PH_TX_ACK;
          end
        end
        PH_TX_ACK:
        begin
          if (scl_rise)
          begin
            s_d.ack_rx_n  = sda_f; // R12
            s_d.byte_done = 1'b1; // R1
            s_d.event_p   = 1'b1;
          end
          else if (scl_fall)
            s_d.phase = s_q.ack_rx_n ? PH_SKIP : PH_HOLD; // R13
        end
        PH_ADDR_ACK, PH_RX_ACK:
        begin
          if (scl_fall)
            s_d.phase = PH_HOLD;
        end
        PH_HOLD:
        begin
          if (acc_done && PADDR == OFF_SHIFT_DATA)
          begin
            s_d.phase   = s_q.tx_role ? PH_TX : PH_RX; // R4
            s_d.bit_cnt = 4'h0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Line drivers
    s_d.scl_oe = (s_d.phase == PH_HOLD);
    s_d.sda_oe = (s_d.phase == PH_ADDR_ACK) // R17
               | ((s_d.phase == PH_RX_ACK) & ~s_q.ack_to_send) // R5 R6
               | ((s_d.phase == PH_TX) & ~s_d.shift[7]);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= ISS_STATE_RST;
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA      = s_q.prdata;
  assign PREADY      = s_q.pready;
  assign PSLVERR     = s_q.pslverr;
  assign SCL_OUT     = 1'b0;
  assign SCL_OE      = s_q.scl_oe;
  assign SDA_OUT     = 1'b0;
  assign SDA_OE      = s_q.sda_oe;
  assign EVENT_PULSE = s_q.event_p;
  assign WAKE_REQ    = s_q.wake_p;

endmodule : iss_slave_ctrl

// File: iss_pkg.sv
// Overview of operation
// R1: Done flag low while shifting; set with event pulse when 8 bits complete (for sent bytes the code sets it at the ninth-clock SCL rise).
// R2: Match flag follows comparison of received address against own address.
// R3: Busy flag set on START, cleared on STOP.
// R4: Role select bit 1 selects transmitter, 0 selects receiver.
// R5: After eight received bits, ack-to-send bit drives SDA in ninth clock.
// R6: Ack-to-send 0 pulls SDA low; 1 leaves SDA released.
// R7: Software clears ack-to-send before further data bytes arrive.
// R8: Read-only direction flag: 1 master reads, 0 master writes.
// R9: After match, software checks direction and sets role select.
// R10: Wake enable set gives wake request on address match.
// R11: Software clears wake enable after wake-up happened.
// R12: After eight sent bits, ninth-clock SDA stored as received-ack (0 = ack).
// R13: Transmitter continues while acked; releases SDA once no ack seen.
// R14: Port enable rising resets status flags; role and ack bits kept.
// R15: Debounce bypassed when wake enable set and clock not high-speed.
// R16: Eighth bit after seven address bits stored as direction flag.
// R17: On address match SDA driven low in ninth bit time.
// R18: Writes to read-only flags ignored.
// R19: Done flag cleared when first bit of next byte begins.
package iss_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_STATUS_CTRL = 12'h000;
  localparam logic [11:0] OFF_OWN_ADDR    = 12'h004;
  localparam logic [11:0] OFF_SHIFT_DATA  = 12'h008;
  localparam logic [11:0] OFF_PORT_CTRL   = 12'h00c;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int          BIT_DONE    = 7;
  localparam int          BIT_MATCH   = 6;
  localparam int          BIT_BUSY    = 5;
  localparam int          BIT_TXROLE  = 4;
  localparam int          BIT_ACKSEND = 3;
  localparam int          BIT_DIR     = 2;
  localparam int          BIT_WAKEEN  = 1;
  localparam int          BIT_ACKRXN  = 0;
  localparam int          BIT_PORTEN  = 1;
  localparam int          POS_DEB     = 2;
  localparam logic [7:0]  SC_RESET    = 8'h81;
  localparam logic [6:0]  OWN_RESET   = 7'h00;

  // ----------------------------------------
  // Timing counts in system clocks and bits per byte
  // ----------------------------------------
  localparam logic [2:0]  DEB_SHORT   = 3'h2;
  localparam logic [2:0]  DEB_LONG    = 3'h4;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_RX, PH_RX_ACK,
    PH_TX, PH_TX_ACK, PH_HOLD, PH_SKIP
  } iss_phase_t;

  typedef struct packed {
    logic [1:0] sync;
    logic [2:0] cnt;
    logic       filt;
  } iss_filt_t;

  typedef struct packed {
    iss_phase_t  phase;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        byte_done;
    logic        addr_match;
    logic        bus_busy;
    logic        tx_role;
    logic        ack_to_send;
    logic        master_dir;
    logic        wake_en;
    logic        ack_rx_n;
    logic [6:0]  own_addr;
    logic [1:0]  deb_sel;
    logic        port_en;
    logic        scl_d;
    logic        sda_d;
    logic        scl_oe;
    logic        sda_oe;
    logic        event_p;
    logic        wake_p;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } iss_regs_t;

  localparam iss_regs_t ISS_STATE_RST = '{
    phase:       PH_IDLE,
    byte_done:   SC_RESET[BIT_DONE],
    ack_rx_n:    SC_RESET[BIT_ACKRXN],
    own_addr:    OWN_RESET,
    scl_d:       1'b1,
    sda_d:       1'b1,
    default:     '0
  };

endpackage : iss_pkg

// File: iss_pin_filter.sv
`timescale 1ns/100ps
module iss_pin_filter
  import iss_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Pin and control
  input  wire logic       pin,
  input  wire logic [1:0] deb_sel,
  input  wire logic       bypass,
  // Filtered level
  output logic            filt
);

  iss_filt_t  f_q;
  iss_filt_t  f_d;
  logic [2:0] target;

  // ----------------------------------------
  // Synchroniser and debounce
  // ----------------------------------------
  always_comb
  begin
    f_d = f_q;
    f_d.sync = {f_q.sync[0], pin};
    target = (deb_sel == 2'h0) ? 3'h0 : (deb_sel == 2'h1) ? DEB_SHORT : DEB_LONG;
    if (bypass || target == 3'h0) // R15
    begin
      f_d.filt = f_q.sync[1];
      f_d.cnt  = 3'h0;
    end
    else if (f_q.sync[1] == f_q.filt)
      f_d.cnt = 3'h0;
    else if (3'(f_q.cnt + 3'h1) >= target)
    begin
      f_d.filt = f_q.sync[1];
      f_d.cnt  = 3'h0;
    end
    else
      f_d.cnt = 3'(f_q.cnt + 3'h1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      f_q <= '{sync: 2'h3, cnt: 3'h0, filt: 1'b1};
    else
      f_q <= f_d;
  end

  assign filt = f_q.filt;

endmodule : iss_pin_filter

// File: iss_slave_ctrl_properties.sv
`timescale 1ns/100ps
module iss_slave_ctrl_properties
  import iss_pkg::*;
(
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        NRST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Bus lines and events
  input wire logic        SCL_IN,
  input wire logic        SCL_OE,
  input wire logic        SDA_OE,
  input wire logic        EVENT_PULSE,
  input wire logic        WAKE_REQ
);
  // ----------
  // Bit mirror
  // ----------
  logic wake_q;
  logic en_q;
  logic acc;
  assign acc = PSEL && PENABLE && PREADY;
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      wake_q <= 1'h0;
      en_q   <= 1'h0;
    end
    else if (acc && PWRITE)
    begin
      if (PADDR == OFF_STATUS_CTRL)
        wake_q <= PWDATA[BIT_WAKEEN];
      if (PADDR == OFF_PORT_CTRL)
        en_q <= PWDATA[BIT_PORTEN];
    end
  end
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  a_ready_wait: assert property ($rose(PENABLE) && PSEL |=> PREADY)
    else $error("ready late");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_err_decode: assert property (acc |-> PSLVERR == (PADDR > OFF_PORT_CTRL))
    else $error("wrong slave error");
  a_event_pulse: assert property (EVENT_PULSE |=> !EVENT_PULSE)
    else $error("event held");
  a_wake_gate: assert property (WAKE_REQ |-> wake_q)
    else $error("wake while disabled");
  a_sda_clock_low: assert property ($changed(SDA_OE) |-> !$past(SCL_IN))
    else $error("data moved with clock high");
  a_off_release: assert property (!en_q ##1 !en_q |-> !SDA_OE && !SCL_OE)
    else $error("lines held while off");
  a_stretch_free: assert property (acc && PADDR == OFF_SHIFT_DATA |=> !SCL_OE)
    else $error("clock not freed");
  c_wake: cover property (WAKE_REQ);
  c_err: cover property (PREADY && PSLVERR);
  c_free: cover property ($fell(SCL_OE));
endmodule : iss_slave_ctrl_properties
bind iss_slave_ctrl iss_slave_ctrl_properties u_props (
  .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_IN(SCL_IN), .SCL_OE(SCL_OE),
  .SDA_OE(SDA_OE), .EVENT_PULSE(EVENT_PULSE), .WAKE_REQ(WAKE_REQ));

// File: iss_i2c_master.sv
`timescale 1ns/100ps
module iss_i2c_master
(
  // Clock and bus lines
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  // Open-drain pull-downs
  output logic      scl_low,
  output logic      sda_low
);
  // -----------
  // Bus actions
  // -----------
  initial
  begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  task automatic hp;
    repeat (20) @(posedge clk);
  endtask : hp
  task automatic rise;
    int n;
    n = 0;
    scl_low <= 1'h0;
    while (scl !== 1'h1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    hp;
  endtask : rise
  task automatic start;
    sda_low <= 1'h1;
    hp;
    scl_low <= 1'h1;
  endtask : start
  task automatic stop;
    sda_low <= 1'h1;
    hp;
    rise;
    sda_low <= 1'h0;
    hp;
  endtask : stop
  task automatic sbit(input logic b, output logic r);
    sda_low <= !b;
    hp;
    rise;
    r = sda;
    scl_low <= 1'h1;
  endtask : sbit
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      sbit(d[i], q[i]);
    sbit(a, k);
    hp;
  endtask : xfer
endmodule : iss_i2c_master

// File: i2c_slave_status_control_test.sv
`timescale 1ns/100ps
module i2c_slave_status_control_test
  import iss_pkg::*;
;
  // -------
  // Harness
  // -------
  localparam logic [11:0] ST = OFF_STATUS_CTRL;
  localparam logic [11:0] DT = OFF_SHIFT_DATA;
  logic        ref_clk = 1'h0;
  logic        nrst = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        scl_oe;
  logic        sda_oe;
  logic        wake;
  logic        evt;
  int          evt_cnt = 0;
  logic [7:0]  q;
  logic        ak;
  int          bad_count = 0;
  int          total_checks = 0;
  int          wake_cnt = 0;
  wire         scl_low;
  wire         sda_low;
  wire         scl_w = !(scl_low | scl_oe);
  wire         sda_w = !(sda_low | sda_oe);
  iss_slave_ctrl u_iss_slave_ctrl (.REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCL_IN(scl_w), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE(sda_oe),
    .SYSCLK_FROM_HS(1'h0), .EVENT_PULSE(evt), .WAKE_REQ(wake));
  iss_i2c_master u_iss_i2c_master (.clk(ref_clk), .scl(scl_w), .sda(sda_w), .scl_low(scl_low),
    .sda_low(sda_low));
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (wake === 1'h1)
      wake_cnt++;
  always @(posedge ref_clk)
    if (evt === 1'h1)
      evt_cnt++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic [31:0] d = 32'h0, input logic w = 1'h0);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1)
      bad_count++;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask : apb
  // ---------
  // Scenarios
  // ---------
  task automatic t_regs;
    apb(ST);
    chk(rd, 32'h81);
    apb(ST, 32'hff, 1'h1);
    apb(ST);
    chk(rd, 32'h9b);
    apb(ST, 32'h02, 1'h1);
    apb(12'h010);
    chk({rd[30:0], pslverr}, 32'h1);
    apb(OFF_OWN_ADDR, 32'h54, 1'h1);
    apb(OFF_PORT_CTRL, 32'h02, 1'h1);
  endtask : t_regs
  task automatic t_write;
    u_iss_i2c_master.start;
    apb(ST);
    chk(rd, 32'ha3);
    u_iss_i2c_master.xfer(8'h54, 1'h1, q, ak);
    chk(ak, 1'h0);
    apb(ST);
    chk(rd, 32'he3);
    chk(wake_cnt, 1);
    apb(ST, 32'h0, 1'h1);
    apb(DT);
    fork
      u_iss_i2c_master.xfer(8'ha5, 1'h1, q, ak);
      begin
        repeat (200) @(posedge ref_clk);
        apb(ST);
        chk(rd[BIT_DONE], 1'h0);
      end
    join
    chk(ak, 1'h0);
    apb(ST);
    chk(rd[BIT_DONE], 1'h1);
    apb(ST, 32'h08, 1'h1);
    apb(DT);
    chk(rd, 32'ha5);
    u_iss_i2c_master.xfer(8'h3c, 1'h1, q, ak);
    chk(ak, 1'h1);
    apb(ST, 32'h0, 1'h1);
    apb(DT);
    chk(rd, 32'h3c);
    u_iss_i2c_master.stop;
    apb(ST);
    chk(rd[BIT_BUSY], 1'h0);
    chk(evt_cnt, 3);
  endtask : t_write
  task automatic t_read;
    apb(OFF_PORT_CTRL, 32'h06, 1'h1);
    apb(OFF_PORT_CTRL);
    chk(rd, 32'h06);
    u_iss_i2c_master.start;
    u_iss_i2c_master.xfer(8'h55, 1'h1, q, ak);
    chk(ak, 1'h0);
    apb(ST);
    chk(rd[BIT_DIR], 1'h1);
    apb(ST, 32'h10, 1'h1);
    apb(DT, 32'hc3, 1'h1);
    u_iss_i2c_master.xfer(8'hff, 1'h0, q, ak);
    chk(q, 8'hc3);
    apb(ST);
    chk(rd[BIT_ACKRXN], 1'h0);
    apb(DT, 32'h96, 1'h1);
    u_iss_i2c_master.xfer(8'hff, 1'h1, q, ak);
    chk(q, 8'h96);
    apb(ST);
    chk(rd[BIT_ACKRXN], 1'h1);
    chk(sda_oe, 1'h0);
    u_iss_i2c_master.stop;
    chk(evt_cnt, 6);
  endtask : t_read
  task automatic t_other;
    u_iss_i2c_master.start;
    u_iss_i2c_master.xfer(8'h20, 1'h1, q, ak);
    chk(ak, 1'h1);
    apb(ST);
    chk(rd[BIT_MATCH], 1'h0);
    u_iss_i2c_master.stop;
    apb(ST, 32'h18, 1'h1);
    u_iss_i2c_master.start;
    apb(OFF_PORT_CTRL, 32'h0, 1'h1);
    apb(OFF_PORT_CTRL, 32'h02, 1'h1);
    apb(ST);
    chk(rd, 32'h99);
    u_iss_i2c_master.stop;
  endtask : t_other
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'h1;
    repeat (4) @(posedge ref_clk);
    t_regs;
    t_write;
    t_read;
    t_other;
    end_sim;
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    end_sim;
  end
endmodule : i2c_slave_status_control_test
